// ---- verification/testbench.sv ----
// self-checking bench for the fault-injection error-record node
`timescale 1ns/10ps

module testbench;
  import fault_inject_pkg::*;
  // ==========================================================
  // stimulus and observation signals
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic CLK_EN = 1'b1;
  logic RECOVERY_RESET_N = 1'b1;
  logic [7:0] RECORD_SELECT = 8'h00;
  logic [1:0] REG_ID = 2'h0;
  logic REG_WRITE = 1'b0;
  logic REG_READ = 1'b0;
  logic [31:0] REG_WDATA = 32'h00000000;
  logic [31:0] REG_RDATA;
  logic LOCKSTEP_PIN = 1'b0;
  logic RECOVERY_IRQ_EN = 1'b0;
  logic FAULT_IRQ;
  logic INJECT_PULSE;
  int failures = 0;
  int tests_run = 0;
  int n;
  logic [31:0] rdata;
  logic [31:0] e;
  logic [31:0] reload;
  logic [7:0] en;
  // uncontainable, corrected with overflow, deferred, unsupported classes only, everything
  logic [7:0] en_table [5] = '{8'h02, 8'h41, 8'h20, 8'h1C, 8'hFF};

  fault_inject_node i_fault_inject_node
  (
    .CLK(CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .RECOVERY_RESET_N(RECOVERY_RESET_N),
    .RECORD_SELECT(RECORD_SELECT), .REG_ID(REG_ID), .REG_WRITE(REG_WRITE),
    .REG_READ(REG_READ), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .LOCKSTEP_PIN(LOCKSTEP_PIN), .RECOVERY_IRQ_EN(RECOVERY_IRQ_EN),
    .FAULT_IRQ(FAULT_IRQ), .INJECT_PULSE(INJECT_PULSE)
  );

  // ==========================================================
  // clock, 10 ns period
  initial
  begin
    forever #5 CLK = ~CLK;
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // strobe for one edge, then one idle edge so strobes never touch
  task automatic wr(input logic [1:0] id, input logic [31:0] d);
    REG_ID = id;
    REG_WDATA = d;
    REG_WRITE = 1'b1;
    @(posedge CLK);
    #1 REG_WRITE = 1'b0;
    @(posedge CLK);
    #1;
  endtask

  // read data is registered and held, so sample one edge after the taken edge
  task automatic rd(input logic [1:0] id, output logic [31:0] d);
    REG_ID = id;
    REG_READ = 1'b1;
    @(posedge CLK);
    #1 REG_READ = 1'b0;
    @(posedge CLK);
    #1 d = REG_RDATA;
  endtask

  // bounded wait; returns lim when no pulse came
  task automatic wait_pulse(input int lim, output int cnt);
    cnt = 0;
    while (INJECT_PULSE !== 1'b1 && cnt < lim)
    begin
      @(posedge CLK);
      #1 cnt++;
    end
  endtask

  // status expected after one injected record from enable byte c
  function automatic logic [31:0] exp_st(input logic [7:0] c);
    logic [31:0] s;
    s = 32'h00000000;
    if (c[7:6] != 2'h0 || c[5] || c[1])
    begin
      s[30] = 1'b1;
      s[27] = c[0];
    end
    if (c[7:6] != 2'h0)
    begin
      s[25:24] = 2'h2;
    end
    s[23] = c[5];
    s[29] = c[1];
    s[28] = c[1];
    return s;
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(40076));
    repeat (5) @(posedge CLK);
    #1 RESET_N = 1'b1;
    // reset values, read-only features, writable control fields
    rd(REG_CONTROL, rdata);
    chk(rdata, 32'h00000000);
    rd(REG_STATUS, rdata);
    chk(rdata, 32'h00000000);
    wr(REG_FEATURES, $urandom);
    rd(REG_FEATURES, rdata);
    chk(rdata, 32'hC0000062);
    rdata = $urandom & 32'h7FFFFFFF;
    wr(REG_CONTROL, rdata);
    e = rdata & 32'h400000FF;
    rd(REG_CONTROL, rdata);
    chk(rdata, e);
    // another record selected: writes are ignored and reads return zero
    RECORD_SELECT = 8'($urandom_range(255, 1));
    wr(REG_CONTROL, 32'hFFFFFFFF);
    rd(REG_CONTROL, rdata);
    chk(rdata, 32'h00000000);
    RECORD_SELECT = RECORD_SEL_NODE;
    rd(REG_CONTROL, rdata);
    chk(rdata, e);
    $display("test reset and registers done");
    // one-shot injection for each enable pattern, random reload
    for (int i = 0; i < 5; i++)
    begin
      en = en_table[i];
      e = exp_st(en);
      reload = $urandom_range(6, 0);
      RECOVERY_IRQ_EN = 1'($urandom_range(1, 0));
      wr(REG_CONTROL, 32'h00000000);
      wr(REG_STATUS, 32'hFFFFFFFF);
      wr(REG_COUNTDOWN, reload);
      wr(REG_CONTROL, {24'h800000, en});
      wait_pulse(reload + 4, n);
      chk(n, (e != 32'h0) ? reload : reload + 4);
      @(posedge CLK);
      #1 wait_pulse(reload + 4, n);
      chk(n, reload + 4);
      rd(REG_STATUS, rdata);
      chk(rdata, e);
      chk({31'h0, FAULT_IRQ}, {31'h0, e[29] & RECOVERY_IRQ_EN});
    end
    $display("test one-shot injection done");
    // lockstep hides the status, which returns once lockstep ends
    LOCKSTEP_PIN = 1'b1;
    repeat (4) @(posedge CLK);
    #1 rd(REG_STATUS, rdata);
    chk(rdata, 32'h00000000);
    // a clear written in lockstep must not reach the held flags
    wr(REG_STATUS, 32'hFFFFFFFF);
    LOCKSTEP_PIN = 1'b0;
    repeat (4) @(posedge CLK);
    #1 rd(REG_STATUS, rdata);
    chk(rdata, exp_st(8'hFF));
    // error-recovery reset keeps the control register
    RECOVERY_RESET_N = 1'b0;
    @(posedge CLK);
    #1 RECOVERY_RESET_N = 1'b1;
    rd(REG_CONTROL, rdata);
    chk(rdata, 32'h800000FF);
    rd(REG_STATUS, rdata);
    chk(rdata, 32'h00000000);
    chk({31'h0, FAULT_IRQ}, 32'h00000000);
    $display("test lockstep and recovery reset done");
    // restartable countdown fires every reload+1 cycles
    reload = $urandom_range(5, 1);
    wr(REG_CONTROL, 32'h00000000);
    wr(REG_COUNTDOWN, reload);
    wr(REG_CONTROL, 32'hC0000040);
    wait_pulse(reload + 4, n);
    chk(n, reload);
    @(posedge CLK);
    #1 wait_pulse(reload + 4, n);
    chk(n, reload);
    // seven frozen edges: longer than any gap, so a leak shifts the count
    @(posedge CLK);
    #1 CLK_EN = 1'b0;
    repeat (7) @(posedge CLK);
    #1 CLK_EN = 1'b1;
    wait_pulse(reload + 12, n);
    chk(n, reload);
    $display("test restart and clock enable done");
    stop_test();
  end
endmodule

// ---- verilog/fault_inject_node.sv ----
// fault-injection countdown, control/feature registers and primary status flags
// Summary of operation
// - control bits 4,3,2 (latent, signaled, unrecoverable classes) are stored but trigger no injection
// - control bit 1 enables uncontainable injection when the countdown triggers
// - control bit 0 is copied into status overflow on each injected record
// - control resets to zero and survives an error-recovery reset
// - feature register is read-only and reads C0000062
// - feature bit 30 reads one: reload-or-stop is selectable
// - feature bit 29: fault codes are implementation chosen on injection
// - feature bit 12: misc-valid set only if misc syndrome is stored
// - feature bit 11: address record and address-valid left untouched
// - feature bit 10: injected record clears the poison flag
// - feature bit 9: reported flag follows the genuine-error rules
// - feature fields 7:6, 5 and 1 read one, controllable
// - feature bits 4,3,2 read zero, those classes unsupported
// - in paired lockstep mode the status register reads zero
// - status bit 31 is address-valid for the highest-priority error
// - status bit 30 set once any error is recorded
// - status bit 29 uncorrected; interrupt held while set and enabled
// - status bit 28 set once an external abort was signalled
// - status bit 27 overflow, extra error details discarded
// - status bit 26 misc-valid; zero means misc records invalid
// - corrected field 00 or 10, bit 23 deferred, kind always 00
// - control bit 31 set loads reload value and starts counting
// - control bit 30 reloads at zero, otherwise counter stops
// - control bits 7:6 nonzero generate a corrected error, always recorded as corrected field 10
`timescale 1ns/10ps

module fault_inject_node
(
  // clock, cold reset, clock enable
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  // error-recovery reset, same clock domain
  input wire logic RECOVERY_RESET_N,
  // system register access
  input wire logic [7:0] RECORD_SELECT,
  input wire logic [1:0] REG_ID,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  // core mode and interrupt enable
  input wire logic LOCKSTEP_PIN,
  input wire logic RECOVERY_IRQ_EN,
  // events
  output logic FAULT_IRQ,
  output logic INJECT_PULSE
);
  import fault_inject_pkg::*;

  // ==========================================================
  // state
  logic [31:0] control_reg;
  logic [31:0] control_next;
  logic [31:0] reload_reg;
  logic [31:0] reload_next;
  logic [31:0] counter_reg;
  logic [31:0] counter_next;
  count_state_type state_reg;
  count_state_type state_next;
  logic [9:0] status_reg;
  logic [9:0] status_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic irq_reg;
  logic irq_next;
  logic pulse_reg;
  logic pulse_next;
  logic lock_meta_reg;
  logic lock_sync_reg;
  logic fire;
  logic node_sel;

  // full status word: low fields are not held here and read zero
  function automatic logic [31:0] status_word(input logic [9:0] st, input logic lock);
    logic [31:0] w;
    w = 32'h00000000;
    w[31:ST_LOW] = st;
    w[21:20] = UNCORR_KIND_UNCONTAINABLE;
    if (lock)
    begin
      w = 32'h00000000;
    end
    return w;
  endfunction

  assign node_sel = (RECORD_SELECT == RECORD_SEL_NODE);

  // ==========================================================
  // lockstep pin comes from outside: two flops before use
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      lock_meta_reg <= 1'b0;
      lock_sync_reg <= 1'b0;
    end
    else if (CLK_EN)
    begin
      lock_meta_reg <= LOCKSTEP_PIN;
      lock_sync_reg <= lock_meta_reg;
    end
  end

  // ==========================================================
  // control and reload registers; recovery reset leaves them alone
  always_comb
  begin
    control_next = control_reg;
    reload_next = reload_reg;
    if (REG_WRITE && node_sel && REG_ID == REG_CONTROL)
    begin
      control_next = REG_WDATA & CONTROL_WRITE_MASK;
    end
    if (REG_WRITE && node_sel && REG_ID == REG_COUNTDOWN)
    begin
      reload_next = REG_WDATA;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      control_reg <= CONTROL_RESET;
      reload_reg <= COUNTDOWN_RESET;
    end
    else if (CLK_EN)
    begin
      control_reg <= control_next;
      reload_reg <= reload_next;
    end
  end

  // ==========================================================
  // countdown: arming loads on the written value, so the load and the
  // first decrement never collide with a stale counter
  always_comb
  begin
    state_next = state_reg;
    counter_next = counter_reg;
    fire = 1'b0;
    unique case (state_reg)
      COUNT_IDLE:
      begin
        if (control_next[CTL_ARM] && !control_reg[CTL_ARM])
        begin
          state_next = COUNT_RUN;
          counter_next = reload_next;
        end
      end
      COUNT_RUN:
      begin
        if (!control_next[CTL_ARM])
        begin
          state_next = COUNT_IDLE;
        end
        else if (counter_reg == 32'h00000000)
        begin
          fire = 1'b1;
          if (control_reg[CTL_RESTART])
          begin
            counter_next = reload_reg;
          end
          else
          begin
            state_next = COUNT_IDLE;
          end
        end
        else
        begin
          counter_next = counter_reg - 32'h00000001;
        end
      end
    endcase
    if (!RECOVERY_RESET_N)
    begin
      state_next = COUNT_IDLE;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      state_reg <= COUNT_IDLE;
      counter_reg <= COUNTER_RESET;
    end
    else if (CLK_EN)
    begin
      state_reg <= state_next;
      counter_reg <= counter_next;
    end
  end

  // ==========================================================
  // status flags: write one to clear, then injection sets, so a set
  // landing in the clearing cycle is kept
  always_comb
  begin
    status_next = status_reg;
    pulse_next = 1'b0;
    if (REG_WRITE && node_sel && REG_ID == REG_STATUS && !lock_sync_reg)
    begin
      status_next = status_reg & ~REG_WDATA[31:ST_LOW];
    end
    // latent, signaled and unrecoverable classes are unsupported: bits 4:2 never fire
    if (fire && (control_reg[CTL_CE_HI:CTL_CE_LO] != 2'h0 || control_reg[CTL_DEFER]
                 || control_reg[CTL_UNCONT]))
    begin
      pulse_next = 1'b1;
      status_next[ST_VALID - ST_LOW] = 1'b1;
      status_next[ST_OVERFLOW - ST_LOW] = control_reg[CTL_OVERFLOW];
      status_next[ST_POISON - ST_LOW] = 1'b0;
      // address-valid and misc-valid untouched: no address or misc syndrome stored
      if (control_reg[CTL_CE_HI:CTL_CE_LO] != 2'h0)
      begin
        status_next[ST_CE_HI - ST_LOW:ST_CE_LO - ST_LOW] = CE_RECORDED;
      end
      if (control_reg[CTL_DEFER])
      begin
        status_next[ST_POSTPONED - ST_LOW] = 1'b1;
      end
      if (control_reg[CTL_UNCONT])
      begin
        status_next[ST_UNCORR - ST_LOW] = 1'b1;
        status_next[ST_REPORTED - ST_LOW] = 1'b1;
      end
    end
    if (!RECOVERY_RESET_N)
    begin
      status_next = STATUS_RESET;
    end
  end

  // ==========================================================
  // read data and interrupt; outputs come straight from flops
  always_comb
  begin
    rdata_next = rdata_reg;
    irq_next = status_reg[ST_UNCORR - ST_LOW] & RECOVERY_IRQ_EN;
    if (REG_READ)
    begin
      rdata_next = 32'h00000000;
      if (node_sel)
      begin
        unique case (REG_ID)
          REG_CONTROL: rdata_next = control_reg;
          REG_FEATURES: rdata_next = FEATURES_VALUE;
          REG_STATUS: rdata_next = status_word(status_reg, lock_sync_reg);
          REG_COUNTDOWN: rdata_next = reload_reg;
        endcase
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      status_reg <= STATUS_RESET;
      rdata_reg <= 32'h00000000;
      irq_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end
    else if (CLK_EN)
    begin
      status_reg <= status_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      pulse_reg <= pulse_next;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign FAULT_IRQ = irq_reg;
  assign INJECT_PULSE = pulse_reg;

  // ==========================================================
  // checks
  a_feature_read_value: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    CLK_EN && REG_READ && node_sel && REG_ID == REG_FEATURES |=> REG_RDATA == 32'hC0000062)
    else $error("feature register read wrong value");

  a_lockstep_status_zero: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    CLK_EN && REG_READ && node_sel && REG_ID == REG_STATUS && lock_sync_reg
    |=> REG_RDATA == 32'h00000000)
    else $error("status not zero in lockstep");

  a_arm_loads_count: assert property (
    @(posedge CLK) disable iff (!RESET_N || !RECOVERY_RESET_N)
    CLK_EN && state_reg == COUNT_IDLE && control_next[CTL_ARM] && !control_reg[CTL_ARM]
    |=> state_reg == COUNT_RUN && counter_reg == $past(reload_next))
    else $error("arming did not load counter");

  a_count_decrements: assert property (
    @(posedge CLK) disable iff (!RESET_N || !RECOVERY_RESET_N)
    CLK_EN && state_reg == COUNT_RUN && control_next[CTL_ARM] && counter_reg != 32'h0
    |=> counter_reg == $past(counter_reg) - 32'h00000001)
    else $error("counter did not decrement");

  a_stop_at_zero: assert property (
    @(posedge CLK) disable iff (!RESET_N || !RECOVERY_RESET_N)
    CLK_EN && fire && !control_reg[CTL_RESTART] && control_next[CTL_ARM]
    |=> state_reg == COUNT_IDLE)
    else $error("counter did not stop at zero");

  a_inject_sets_valid: assert property (
    @(posedge CLK) disable iff (!RESET_N || !RECOVERY_RESET_N)
    CLK_EN && fire && control_reg[CTL_UNCONT]
    |=> INJECT_PULSE && status_reg[ST_VALID - ST_LOW] && status_reg[ST_UNCORR - ST_LOW])
    else $error("injection did not record uncorrected error");

  a_inject_copies_overflow: assert property (
    @(posedge CLK) disable iff (!RESET_N || !RECOVERY_RESET_N)
    CLK_EN && pulse_next |=> status_reg[ST_OVERFLOW - ST_LOW] == $past(control_reg[CTL_OVERFLOW])
    && !status_reg[ST_POISON - ST_LOW])
    else $error("overflow or poison wrong after injection");

  a_no_class_no_record: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    CLK_EN && fire && control_reg[7:5] == 3'h0 && !control_reg[CTL_UNCONT] |=> !INJECT_PULSE)
    else $error("injection recorded with no class enabled");

  a_irq_follows_uncorr: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    CLK_EN && status_reg[ST_UNCORR - ST_LOW] && RECOVERY_IRQ_EN |=> FAULT_IRQ)
    else $error("interrupt not held while uncorrected set");

endmodule

// ---- verilog/fault_inject_pkg.sv ----
// constants and types shared by the fault-injection error-record node
package fault_inject_pkg;

  // ==========================================================
  // register selection
  localparam logic [7:0] RECORD_SEL_NODE = 8'h00;
  localparam logic [1:0] REG_CONTROL = 2'h0;
  localparam logic [1:0] REG_FEATURES = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [1:0] REG_COUNTDOWN = 2'h3;

  // ==========================================================
  // values after reset
  localparam logic [31:0] CONTROL_RESET = 32'h00000000;
  localparam logic [31:0] FEATURES_VALUE = 32'hC0000062;
  localparam logic [31:0] COUNTDOWN_RESET = 32'h00000000;
  localparam logic [9:0] STATUS_RESET = 10'h000;
  localparam logic [31:0] COUNTER_RESET = 32'h00000000;

  // ==========================================================
  // control field positions
  localparam int CTL_ARM = 31;
  localparam int CTL_RESTART = 30;
  localparam int CTL_CE_HI = 7;
  localparam int CTL_CE_LO = 6;
  localparam int CTL_DEFER = 5;
  localparam int CTL_LATENT = 4;
  localparam int CTL_SIGNALED = 3;
  localparam int CTL_UNRECOV = 2;
  localparam int CTL_UNCONT = 1;
  localparam int CTL_OVERFLOW = 0;
  localparam logic [31:0] CONTROL_WRITE_MASK = 32'hC00000FF;

  // ==========================================================
  // status field positions (the held upper slice is bits 31:22)
  localparam int ST_LOW = 22;
  localparam int ST_ADDR_VALID = 31;
  localparam int ST_VALID = 30;
  localparam int ST_UNCORR = 29;
  localparam int ST_REPORTED = 28;
  localparam int ST_OVERFLOW = 27;
  localparam int ST_MISC_VALID = 26;
  localparam int ST_CE_HI = 25;
  localparam int ST_CE_LO = 24;
  localparam int ST_POSTPONED = 23;
  localparam int ST_POISON = 22;
  localparam logic [1:0] CE_RECORDED = 2'h2;
  localparam logic [1:0] UNCORR_KIND_UNCONTAINABLE = 2'h0;

  // ==========================================================
  // countdown states, gray along idle -> counting
  typedef enum logic [0:0]
  {
    COUNT_IDLE = 1'b0,
    COUNT_RUN = 1'b1
  } count_state_type;

endpackage
